/* hdl/i2crb_dev.sv */
// device end: i2c slave in front of a 128-byte register bank
`timescale 1ns/1ps
// Overview of operation
// - answer address 01000 plus two strap bits
// - bank of 128 byte-wide locations
// - 0..80 read/write, 96..127 read-only
// - master opens with start, address, direction
// - sample data on rising clock edges
// - acknowledge own address by pulling data low
// - acknowledge every written byte on ninth clock
// - master sends register address then data
// - write pointer steps up per data byte
// - stop returns slave to idle
// - read starts with written register address
// - repeated start, read address, slave acknowledges
// - drive selected location after read acknowledge
// - master nack then stop ends read
// - master clocks at no more than 400 kbps (SCL_MAX_KHZ), each quarter rounded up to whole system clocks
module i2crb_dev
    import i2crb_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic addr_select_hi_pin_i,
    input wire logic addr_select_lo_pin_i,
    input wire logic [RO_COUNT*DATA_W-1:0] status_i,
    output logic [RW_COUNT*DATA_W-1:0] cfg_o,
    i2crb_if.dev bus
);

    // system domain state
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic sda_prev_q;
    logic eng_nrst_q;
    logic [1:0] strap_meta_q;
    logic [1:0] strap_q;
    logic [2:0] wr_sync_q;
    logic [2:0] ptr_sync_q;
    logic [ADDR_W-1:0] rd_ptr_q;
    logic rd_load_q;
    logic [DATA_W-1:0] rd_data_q;
    logic [DATA_W-1:0] mem_q [BANK_DEPTH];
    logic start_det;
    logic stop_det;
    logic wr_evt;
    logic ptr_evt;

    // link domain state
    i2crb_dstate_t state_q;
    logic [3:0] cnt_q;
    logic [DATA_W-2:0] sr_q;
    logic ack_q;
    logic [ADDR_W-1:0] ptr_q;
    logic ptr_tgl_q;
    logic wr_tgl_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic [DATA_W-1:0] wr_data_q;
    logic sda_oe_q;
    logic [DATA_W-2:0] tx_q;
    logic [DATA_W-1:0] rx_byte;
    logic [ADDR_W-1:0] own_addr;

    // line watchers: both bus lines pass two flops before the start and stop detectors
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            scl_sync_q <= {scl_sync_q[0], bus.scl};
            sda_sync_q <= {sda_sync_q[0], bus.sda};
            sda_prev_q <= sda_sync_q[1];
        end
    end

    // start: data falls with clock high; stop: data rises with clock high
    assign start_det = scl_sync_q[1] & sda_prev_q & ~sda_sync_q[1];
    assign stop_det = scl_sync_q[1] & ~sda_prev_q & sda_sync_q[1];

    // engine reset: held from any start or stop until the clock goes low,
    // so the link logic is parked while the bus is idle
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            eng_nrst_q <= 1'b0;
        end
        else if (start_det || stop_det)
        begin
            eng_nrst_q <= 1'b0;
        end
        else if (!scl_sync_q[1])
        begin
            eng_nrst_q <= 1'b1;
        end
    end

    // strap pins pass two flops and are resampled on every system clock
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            strap_meta_q <= 2'h0;
            strap_q <= 2'h0;
        end
        else
        begin
            strap_meta_q <= {addr_select_hi_pin_i, addr_select_lo_pin_i};
            strap_q <= strap_meta_q;
        end
    end

    assign own_addr = {DEV_ADDR_HI, strap_q};

    // toggle crossings from the link domain; bit 2 keeps the last value
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wr_sync_q <= 3'h0;
            ptr_sync_q <= 3'h0;
        end
        else
        begin
            wr_sync_q <= {wr_sync_q[1:0], wr_tgl_q};
            ptr_sync_q <= {ptr_sync_q[1:0], ptr_tgl_q};
        end
    end

    assign wr_evt = wr_sync_q[2] ^ wr_sync_q[1];
    assign ptr_evt = ptr_sync_q[2] ^ ptr_sync_q[1];

    // register bank: writable low part, read-only status part, gap reads zero
    for (genvar i = 0; i < BANK_DEPTH; i++)
    begin : g_bank
        if (i <= RW_LAST)
        begin : g_rw
            always_ff @(posedge clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    mem_q[i] <= BANK_RST;
                end
                else if (wr_evt && wr_addr_q == ADDR_W'(i))
                begin
                    mem_q[i] <= wr_data_q;
                end
            end
            assign cfg_o[i*DATA_W +: DATA_W] = mem_q[i];
        end
        else if (i >= RO_FIRST)
        begin : g_ro
            // writes never reach these; they mirror the status inputs
            always_ff @(posedge clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    mem_q[i] <= BANK_RST;
                end
                else
                begin
                    mem_q[i] <= status_i[(i-RO_FIRST)*DATA_W +: DATA_W];
                end
            end
        end
        else
        begin : g_gap
            assign mem_q[i] = BANK_RST;
        end
    end

    // read snapshot: taken once per pointer change and then held still,
    // so the link side can read it on its next falling edge
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rd_ptr_q <= '0;
            rd_load_q <= 1'b0;
            rd_data_q <= BANK_RST;
        end
        else
        begin
            rd_load_q <= ptr_evt;
            if (ptr_evt)
            begin
                rd_ptr_q <= ptr_q;
            end
            if (rd_load_q)
            begin
                rd_data_q <= mem_q[rd_ptr_q];
            end
        end
    end

    assign rx_byte = {sr_q, bus.sda};

    // receive engine on the rising clock edge
    always_ff @(posedge bus.scl or negedge eng_nrst_q)
    begin
        if (!eng_nrst_q)
        begin
            state_q <= DS_ADDR;
            cnt_q <= BIT_FIRST;
            sr_q <= '0;
            ack_q <= 1'b0;
        end
        else
        begin
            cnt_q <= (cnt_q == BIT_ACK) ? BIT_FIRST : cnt_q + 4'd1;
            if (cnt_q == BIT_ACK)
            begin
                ack_q <= 1'b0;
                if (state_q == DS_RDATA && !ack_q && bus.sda)
                begin
                    state_q <= DS_IGNORE;
                end
            end
            else
            begin
                sr_q <= rx_byte[DATA_W-2:0];
            end
            if (cnt_q == BIT_LAST)
            begin
                case (state_q)
                    DS_ADDR:
                    begin
                        if (rx_byte[DATA_W-1:1] == own_addr)
                        begin
                            ack_q <= 1'b1;
                            state_q <= (rx_byte[0] == RW_READ) ? DS_RDATA : DS_REG;
                        end
                        else
                        begin
                            state_q <= DS_IGNORE;
                        end
                    end
                    DS_REG:
                    begin
                        ack_q <= 1'b1;
                        state_q <= DS_WDATA;
                    end
                    DS_WDATA:
                    begin
                        ack_q <= 1'b1;
                    end
                    default:
                    begin
                        ack_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // pointer and write hand-off; survives repeated starts
    always_ff @(posedge bus.scl or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ptr_q <= '0;
            ptr_tgl_q <= 1'b0;
            wr_tgl_q <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= BANK_RST;
        end
        else if (cnt_q == BIT_LAST && state_q == DS_REG)
        begin
            ptr_q <= rx_byte[ADDR_W-1:0];
            ptr_tgl_q <= ~ptr_tgl_q;
        end
        else if (cnt_q == BIT_LAST && state_q == DS_WDATA)
        begin
            wr_addr_q <= ptr_q;
            wr_data_q <= rx_byte;
            wr_tgl_q <= ~wr_tgl_q;
            ptr_q <= ptr_q + 7'd1;
            ptr_tgl_q <= ~ptr_tgl_q;
        end
        else if (cnt_q == BIT_ACK && state_q == DS_RDATA && !ack_q && !bus.sda)
        begin
            ptr_q <= ptr_q + 7'd1;
            ptr_tgl_q <= ~ptr_tgl_q;
        end
    end

    // line driver on the falling edge: ack slot or next read bit
    always_ff @(negedge bus.scl or negedge eng_nrst_q)
    begin
        if (!eng_nrst_q)
        begin
            sda_oe_q <= 1'b0;
            tx_q <= '0;
        end
        else if (cnt_q == BIT_ACK)
        begin
            sda_oe_q <= ack_q;
        end
        else if (state_q == DS_RDATA && cnt_q == BIT_FIRST)
        begin
            sda_oe_q <= ~rd_data_q[DATA_W-1];
            tx_q <= rd_data_q[DATA_W-2:0];
        end
        else if (state_q == DS_RDATA)
        begin
            sda_oe_q <= ~tx_q[DATA_W-2];
            tx_q <= {tx_q[DATA_W-3:0], 1'b0};
        end
        else
        begin
            sda_oe_q <= 1'b0;
        end
    end

    // open-drain: the output value is always low, the enable pulls
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = sda_oe_q;

endmodule

/* hdl/i2crb_host.sv */
// host end: i2c master that writes or reads one register byte
`timescale 1ns/1ps
module i2crb_host
    import i2crb_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_read_i,
    input wire logic [1:0] cmd_sel_i,
    input wire logic [ADDR_W-1:0] cmd_reg_i,
    input wire logic [DATA_W-1:0] cmd_data_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic rsp_nack_o,
    output logic [DATA_W-1:0] rsp_data_o,
    i2crb_if.host bus
);

    i2crb_hstate_t state_q;
    logic [1:0] ph_q;
    logic [2:0] step_q;
    logic [3:0] bit_q;
    logic [DATA_W:0] tx_q;
    logic [DATA_W-1:0] rx_q;
    logic ack_ok_q;
    logic read_q;
    logic [1:0] sel_q;
    logic [ADDR_W-1:0] reg_q;
    logic [DATA_W-1:0] data_q;
    logic scl_oe_q;
    logic sda_oe_q;
    logic cmd_ready_q;
    logic rsp_valid_q;
    logic rsp_nack_q;
    logic [DATA_W-1:0] rsp_data_q;
    logic [9:0] qcnt_q;
    logic [1:0] sda_sync_q;
    logic tick;

    // address byte with its trailing released ack slot
    function automatic logic [DATA_W:0] addr_byte(input logic [1:0] sel, input logic rd);
        addr_byte = {DEV_ADDR_HI, sel, (rd ? RW_READ : RW_WRITE), 1'b1};
    endfunction

    // data line comes from the other domain: two flops first
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sda_sync_q <= 2'h3;
        end
        else
        begin
            sda_sync_q <= {sda_sync_q[0], bus.sda};
        end
    end

    // quarter-period divider, scl at the top listed rate from the system clock
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            qcnt_q <= '0;
        end
        else if (state_q == HS_IDLE || qcnt_q == QTR_LAST)
        begin
            qcnt_q <= '0;
        end
        else
        begin
            qcnt_q <= qcnt_q + 10'd1;
        end
    end

    assign tick = (qcnt_q == QTR_LAST);

    // transfer sequencer
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q <= HS_IDLE;
            ph_q <= PH_LOW;
            step_q <= STEP_ADDR_W;
            bit_q <= BIT_FIRST;
            tx_q <= '1;
            rx_q <= '0;
            ack_ok_q <= 1'b0;
            read_q <= 1'b0;
            sel_q <= 2'h0;
            reg_q <= '0;
            data_q <= '0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            cmd_ready_q <= 1'b1;
            rsp_valid_q <= 1'b0;
            rsp_nack_q <= 1'b0;
            rsp_data_q <= '0;
        end
        else
        begin
            rsp_valid_q <= 1'b0;
            case (state_q)
                HS_IDLE:
                begin
                    if (cmd_valid_i)
                    begin
                        read_q <= cmd_read_i;
                        sel_q <= cmd_sel_i;
                        reg_q <= cmd_reg_i;
                        data_q <= cmd_data_i;
                        cmd_ready_q <= 1'b0;
                        rsp_nack_q <= 1'b0;
                        step_q <= STEP_ADDR_W;
                        ph_q <= PH_RISE;   // clock already high: no extra pulse
                        state_q <= HS_START;
                    end
                end
                HS_START:
                begin
                    if (tick)
                    begin
                        ph_q <= ph_q + 2'd1;
                        case (ph_q)
                            PH_LOW: sda_oe_q <= 1'b0;
                            PH_RISE: scl_oe_q <= 1'b0;
                            PH_HIGH: sda_oe_q <= 1'b1;
                            default:
                            begin
                                scl_oe_q <= 1'b1;
                                bit_q <= BIT_FIRST;
                                tx_q <= addr_byte(sel_q, step_q == STEP_ADDR_R);
                                state_q <= HS_BYTE;
                            end
                        endcase
                    end
                end
                HS_BYTE:
                begin
                    if (tick)
                    begin
                        ph_q <= ph_q + 2'd1;
                        case (ph_q)
                            PH_LOW: sda_oe_q <= ~tx_q[DATA_W];
                            PH_RISE: scl_oe_q <= 1'b0;
                            PH_HIGH:
                            begin
                                if (bit_q == BIT_ACK)
                                begin
                                    ack_ok_q <= ~sda_sync_q[1];
                                end
                                else
                                begin
                                    rx_q <= {rx_q[DATA_W-2:0], sda_sync_q[1]};
                                end
                            end
                            default:
                            begin
                                scl_oe_q <= 1'b1;
                                tx_q <= {tx_q[DATA_W-1:0], 1'b1};
                                bit_q <= bit_q + 4'd1;
                                if (bit_q == BIT_ACK)
                                begin
                                    bit_q <= BIT_FIRST;
                                    if (step_q != STEP_RDATA && !ack_ok_q)
                                    begin
                                        rsp_nack_q <= 1'b1;
                                        state_q <= HS_STOP;
                                    end
                                    else
                                    begin
                                        case (step_q)
                                            STEP_ADDR_W:
                                            begin
                                                step_q <= STEP_REG;
                                                tx_q <= {1'b0, reg_q, 1'b1};
                                            end
                                            STEP_REG:
                                            begin
                                                if (read_q)
                                                begin
                                                    step_q <= STEP_ADDR_R;
                                                    state_q <= HS_START;
                                                end
                                                else
                                                begin
                                                    step_q <= STEP_DATA;
                                                    tx_q <= {data_q, 1'b1};
                                                end
                                            end
                                            STEP_ADDR_R:
                                            begin
                                                step_q <= STEP_RDATA;
                                                tx_q <= '1;
                                            end
                                            default: state_q <= HS_STOP;
                                        endcase
                                    end
                                end
                            end
                        endcase
                    end
                end
                HS_STOP:
                begin
                    if (tick)
                    begin
                        ph_q <= ph_q + 2'd1;
                        case (ph_q)
                            PH_LOW: sda_oe_q <= 1'b1;
                            PH_RISE: scl_oe_q <= 1'b0;
                            PH_HIGH: sda_oe_q <= 1'b0;
                            default:
                            begin
                                rsp_data_q <= rx_q;
                                rsp_valid_q <= 1'b1;
                                cmd_ready_q <= 1'b1;
                                state_q <= HS_IDLE;
                            end
                        endcase
                    end
                end
                default: state_q <= HS_IDLE;
            endcase
        end
    end

    assign bus.host_scl_o = 1'b0;
    assign bus.host_scl_oe = scl_oe_q;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_sda_oe = sda_oe_q;
    assign cmd_ready_o = cmd_ready_q;
    assign rsp_valid_o = rsp_valid_q;
    assign rsp_nack_o = rsp_nack_q;
    assign rsp_data_o = rsp_data_q;

endmodule

/* hdl/i2crb_if.sv */
// two-wire bus joining the host end and the device end
`timescale 1ns/1ps
interface i2crb_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;
    // wired-and with pull-ups: any enabled low output pulls the line down
    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host (input sda, output host_scl_o, output host_scl_oe,
                  output host_sda_o, output host_sda_oe);
endinterface

/* hdl/i2crb_pkg.sv */
// shared constants and state types for the i2c register bank link
package i2crb_pkg;
    // register bank shape
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int BANK_DEPTH = 128;
    localparam int RW_LAST = 80;
    localparam int RO_FIRST = 96;
    localparam int RO_LAST = 127;
    localparam int RW_COUNT = RW_LAST + 1;
    localparam int RO_COUNT = RO_LAST - RO_FIRST + 1;
    localparam logic [DATA_W-1:0] BANK_RST = 8'h00;
    // slave address: fixed upper bits 01000, low two bits from straps
    localparam logic [4:0] DEV_ADDR_HI = 5'h08;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;
    // bit positions within a nine-clock byte slot
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // host bit timing: top listed rate split into four quarters, rounded
    // up so the clock never runs faster than the limit
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SCL_RATE_KHZ = 100;
    localparam int SCL_MAX_KHZ = 400;
    localparam int SCL_PERIOD_PS = 1000000000 / SCL_MAX_KHZ;
    localparam int QTR_CYCLES = (SCL_PERIOD_PS + 4 * CLK_PERIOD_PS - 1) / (4 * CLK_PERIOD_PS);
    localparam logic [9:0] QTR_LAST = 10'(QTR_CYCLES - 1);
    // host transfer steps
    localparam logic [2:0] STEP_ADDR_W = 3'h0;
    localparam logic [2:0] STEP_REG = 3'h1;
    localparam logic [2:0] STEP_DATA = 3'h2;
    localparam logic [2:0] STEP_ADDR_R = 3'h3;
    localparam logic [2:0] STEP_RDATA = 3'h4;
    // quarter phases of one scl period
    localparam logic [1:0] PH_LOW = 2'h0;
    localparam logic [1:0] PH_RISE = 2'h1;
    localparam logic [1:0] PH_HIGH = 2'h2;
    typedef enum logic [2:0] {DS_ADDR, DS_REG, DS_WDATA, DS_RDATA, DS_IGNORE} i2crb_dstate_t;
    typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BYTE, HS_STOP} i2crb_hstate_t;
endpackage

/* tb/i2c_register_bank_slave_tb.sv */
// self-checking bench for the host and device ends of the link
`timescale 1ns/1ps
module i2c_register_bank_slave_tb
    import i2crb_pkg::*;
;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic cv = 1'b0;
    logic crd = 1'b0;
    logic [1:0] csel = 2'h0;
    logic [1:0] strap = 2'h0;
    logic [6:0] creg = 7'h00;
    logic [7:0] cdat = 8'h00;
    logic [RO_COUNT*DATA_W-1:0] stat = '0;
    logic [RW_COUNT*DATA_W-1:0] cfg;
    logic rdy;
    logic rv;
    logic rn;
    logic [7:0] rdat;
    logic [7:0] mem [128];
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    int seed = 12;
    i2crb_if i2crb_if_inst ();
    i2crb_host i2crb_host_inst (.clk_i(clk_i), .nrst_i(nrst_i), .cmd_valid_i(cv),
        .cmd_read_i(crd), .cmd_sel_i(csel), .cmd_reg_i(creg), .cmd_data_i(cdat),
        .cmd_ready_o(rdy), .rsp_valid_o(rv), .rsp_nack_o(rn), .rsp_data_o(rdat),
        .bus(i2crb_if_inst.host));
    i2crb_dev i2crb_dev_inst (.clk_i(clk_i), .nrst_i(nrst_i), .addr_select_hi_pin_i(strap[1]),
        .addr_select_lo_pin_i(strap[0]), .status_i(stat), .cfg_o(cfg), .bus(i2crb_if_inst.dev));
    i2crb_properties i2crb_properties_inst (.clk_i(clk_i), .nrst_i(nrst_i),
        .scl(i2crb_if_inst.scl), .sda(i2crb_if_inst.sda), .dev_sda_oe(i2crb_if_inst.dev_sda_oe));
    // system clock
    always #2 clk_i = ~clk_i;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // bench model of one bank location
    function automatic logic [7:0] model(input int r);
        if (r <= RW_LAST)
            return mem[r];
        return (r >= RO_FIRST) ? stat[(r-RO_FIRST)*8 +: 8] : 8'h00;
    endfunction
    // one command through the host, checked against the model
    task automatic xfer(input logic rd, input logic [1:0] sel, input int r, input logic [7:0] d);
        logic hit;
        hit = (sel == strap);
        cv <= 1'b1;
        crd <= rd;
        csel <= sel;
        creg <= 7'(r);
        cdat <= d;
        @(posedge clk_i);
        cv <= 1'b0;
        do @(posedge clk_i); while (rv !== 1'b1);
        check({7'h00, rn}, {7'h00, ~hit});
        check({7'h00, rdy}, 8'h01);
        if (rd)
            check(rdat, model(r));
        else if (hit && r <= RW_LAST)
            mem[r] = d;
        if (r <= RW_LAST)
            check(cfg[r*8 +: 8], mem[r]);
        $display("test done rd=%0d reg=%0d", rd, r);
    endtask
    // watchdog on total run length
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 100000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end
    // main sequence
    initial
    begin
        int r;
        logic [7:0] d;
        strap = 2'($random(seed));
        stat = {8{$random(seed)}};
        for (int i = 0; i < 128; i++)
            mem[i] = 8'h00;
        r = $unsigned($random(seed)) % (RW_LAST + 1);
        d = 8'($random(seed));
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        xfer(1'b0, strap, r, d);
        xfer(1'b1, strap, r, 8'h00);
        xfer(1'b0, strap, RO_FIRST + 4, ~d);
        xfer(1'b1, strap, RO_FIRST + 4, 8'h00);
        xfer(1'b0, strap ^ 2'h1, r, ~d);
        wrap_up();
    end
endmodule

/* tb/i2crb_properties.sv */
// bus checks between the host and device ends
`timescale 1ns/1ps
module i2crb_properties (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_oe
);
    logic scl_q;
    logic sda_q;
    logic [9:0] hi_q;
    logic [9:0] lo_q;
    logic sta;
    logic sto;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // delayed line levels for start and stop detection
    always_ff @(posedge clk_i or negedge nrst_i)
        if (!nrst_i) {scl_q, sda_q} <= 2'h3;
        else {scl_q, sda_q} <= {scl, sda};
    assign sta = scl & scl_q & sda_q & ~sda;
    assign sto = scl & scl_q & ~sda_q & sda;
    // saturating lengths of the clock high and low phases
    always_ff @(posedge clk_i or negedge nrst_i)
        if (!nrst_i) {hi_q, lo_q} <= 20'h00000;
        else
        begin
            hi_q <= scl ? hi_q + {9'h000, ~&hi_q} : 10'h000;
            lo_q <= scl ? 10'h000 : lo_q + {9'h000, ~&lo_q};
        end
    a_oe_on_fall: assert property ($changed(dev_sda_oe) |-> $fell(scl))
        else $error("device drive moved off a clock fall");
    a_oe_setup_low: assert property ($changed(dev_sda_oe) |-> !scl [*8])
        else $error("clock rose right after device drive changed");
    a_ack_line_low: assert property ($rose(scl) && dev_sda_oe |-> !sda [*8])
        else $error("driven bit not low while clock high");
    a_start_quiet: assert property (sta |-> !dev_sda_oe)
        else $error("device driving at start");
    a_stop_release: assert property (sto |-> !dev_sda_oe [*8])
        else $error("device drives after stop");
    a_scl_high_time: assert property ($fell(scl) |-> hi_q >= 10'h0fa)
        else $error("clock high too short");
    a_scl_low_time: assert property ($rose(scl) |-> lo_q >= 10'h0fa)
        else $error("clock low too short");
    a_start_clocks: assert property (sta |-> ##[1:1000] !scl)
        else $error("no clock after start");
    c_start: cover property (sta);
    c_dev_drive: cover property ($rose(dev_sda_oe));
    c_stop: cover property (sto);
endmodule
